// >>> src/hssp_defs.vh
`ifndef HSSP_DEFS_VH
`define HSSP_DEFS_VH
// ----------------------------------------------------------------
// command codes of the serial protocol
// ----------------------------------------------------------------
`define HSSP_CMD_REG_WR 8'hc1
`define HSSP_CMD_REG_RD 8'hc2
`define HSSP_CMD_DMA 8'hc3
`define HSSP_CMD_NET 8'hc4
// ----------------------------------------------------------------
// protocol phases
// ----------------------------------------------------------------
`define HSSP_ST_CMD 3'h0
`define HSSP_ST_ADDR 3'h1
`define HSSP_ST_DATA 3'h2
`define HSSP_ST_NET 3'h3
`define HSSP_ST_IGNORE 3'h4
// ----------------------------------------------------------------
// sizes, reset and fill values
// ----------------------------------------------------------------
`define HSSP_REG_DEPTH 16
`define HSSP_REG_AW 4
`define HSSP_REG_RESET 8'h00
`define HSSP_IDLE_BYTE 8'h00
`define HSSP_LAST_BIT 3'h7
`endif

// >>> src/hssp_port.v
// Functional notes
// - serial slave only, ready after reset when strapped
// - active low select gates all activity
// - sample master-out, drive master-in
// - master-in released while deselected
// - protocol reads/writes registers, starts dma
// - network data shares the same port
// - four polarity/phase modes, both ends agree
`timescale 1ns/100ps
`default_nettype none
`include "hssp_defs.vh"
module hssp_port (
    input wire clock,
    input wire rstn,
    input wire spi_sck,
    input wire spi_ssn_n,
    input wire spi_mosi,
    input wire spi_cfg,
    input wire mode_cpol,
    input wire mode_cpha,
    input wire [7:0] net_tx_data,
    output reg spi_miso_out,
    output reg spi_miso_oe,
    output reg dma_start,
    output reg [7:0] dma_addr,
    output reg [7:0] dma_len,
    output reg net_rx_valid,
    output reg [7:0] net_rx_data,
    output reg net_tx_taken
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    reg [4:0] sync1_reg; // first stage, read only by second
    reg [4:0] sync2_reg; // second stage
    reg sck_prev_reg; // last synced clock level
    reg sel_prev_reg; // last select state
    wire sck_s = sync2_reg[0];
    wire ssn_s = sync2_reg[1];
    wire mosi_s = sync2_reg[2];
    wire cfg_s = sync2_reg[3];
    wire cpha_s = sync2_reg[4];
    reg cpol_reg; // synced polarity
    reg cpol_meta_reg; // first stage of polarity
    // two flops on every pin
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= 5'h0a;
            sync2_reg <= 5'h0a;
            cpol_meta_reg <= 1'b0;
            cpol_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {mode_cpha, spi_cfg, spi_mosi, spi_ssn_n, spi_sck};
            sync2_reg <= sync1_reg;
            cpol_meta_reg <= mode_cpol;
            cpol_reg <= cpol_meta_reg;
        end
    end
    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    // port live only with strap high
    wire selected = cfg_s & ~ssn_s;
    wire sel_start = selected & ~sel_prev_reg;
    wire rise = sck_s & ~sck_prev_reg;
    wire fall = ~sck_s & sck_prev_reg;
    // leading edge leaves the idle level
    wire lead = cpol_reg ? fall : rise;
    wire trail = cpol_reg ? rise : fall;
    wire samp_edge = selected & ~sel_start & (cpha_s ? trail : lead);
    wire shift_edge = selected & ~sel_start & (cpha_s ? lead : trail);
    // ----------------------------------------------------------------
    // shift and protocol state
    // ----------------------------------------------------------------
    reg [2:0] bit_cnt_reg; // bits taken in this byte
    reg [7:0] rx_shift_reg; // incoming byte
    reg [7:0] tx_shift_reg; // outgoing byte
    reg [2:0] state_reg; // protocol phase
    reg [7:0] cmd_reg; // current command
    reg [7:0] addr_reg; // address byte
    reg [7:0] mem_reg [0:`HSSP_REG_DEPTH-1]; // host visible registers
    wire [7:0] idle_byte = `HSSP_IDLE_BYTE; // filler reply byte
    wire [7:0] rx_byte = {rx_shift_reg[6:0], mosi_s};
    wire byte_done = samp_edge & (bit_cnt_reg == `HSSP_LAST_BIT);
    wire [`HSSP_REG_AW-1:0] rx_idx = rx_byte[`HSSP_REG_AW-1:0];
    wire [`HSSP_REG_AW-1:0] addr_idx = addr_reg[`HSSP_REG_AW-1:0];
    reg [2:0] state_next;
    reg [7:0] tx_next;
    // next phase and reply byte per finished byte
    always @*
    begin
        state_next = state_reg;
        tx_next = `HSSP_IDLE_BYTE;
        case (state_reg)
            `HSSP_ST_CMD:
            begin
                if (rx_byte == `HSSP_CMD_REG_WR || rx_byte == `HSSP_CMD_REG_RD
                    || rx_byte == `HSSP_CMD_DMA)
                    state_next = `HSSP_ST_ADDR;
                else if (rx_byte == `HSSP_CMD_NET)
                begin
                    state_next = `HSSP_ST_NET;
                    tx_next = net_tx_data;
                end
                else
                    state_next = `HSSP_ST_IGNORE;
            end
            `HSSP_ST_ADDR:
            begin
                // read data returned in next byte
                if (cmd_reg == `HSSP_CMD_REG_RD)
                begin
                    tx_next = mem_reg[rx_idx];
                    state_next = `HSSP_ST_IGNORE;
                end
                else
                    state_next = `HSSP_ST_DATA;
            end
            `HSSP_ST_DATA:
                state_next = `HSSP_ST_IGNORE;
            `HSSP_ST_NET:
                tx_next = net_tx_data;
            `HSSP_ST_IGNORE:
                state_next = `HSSP_ST_IGNORE;
            default:
                state_next = `HSSP_ST_IGNORE;
        endcase
    end
    // serial engine and protocol sequencing
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            state_reg <= `HSSP_ST_CMD;
            cmd_reg <= 8'h00;
            addr_reg <= 8'h00;
            spi_miso_out <= 1'b0;
            spi_miso_oe <= 1'b0;
            dma_start <= 1'b0;
            dma_addr <= 8'h00;
            dma_len <= 8'h00;
            net_rx_valid <= 1'b0;
            net_rx_data <= 8'h00;
            net_tx_taken <= 1'b0;
        end
        else
        begin
            sck_prev_reg <= sck_s;
            sel_prev_reg <= selected;
            dma_start <= 1'b0;
            net_rx_valid <= 1'b0;
            net_tx_taken <= 1'b0;
            spi_miso_oe <= selected;
            if (!selected)
            begin
                bit_cnt_reg <= 3'h0;
                rx_shift_reg <= 8'h00;
                state_reg <= `HSSP_ST_CMD;
                spi_miso_out <= 1'b0;
            end
            else if (sel_start)
            begin
                // phase 0 must present first bit before first edge
                if (!cpha_s)
                begin
                    spi_miso_out <= idle_byte[7];
                    tx_shift_reg <= {idle_byte[6:0], 1'b0};
                end
                else
                    tx_shift_reg <= `HSSP_IDLE_BYTE;
            end
            else
            begin
                if (samp_edge)
                begin
                    rx_shift_reg <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                end
                if (shift_edge)
                begin
                    spi_miso_out <= tx_shift_reg[7];
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                end
                if (byte_done)
                begin
                    tx_shift_reg <= tx_next;
                    state_reg <= state_next;
                    if (state_reg == `HSSP_ST_CMD)
                        cmd_reg <= rx_byte;
                    if (state_reg == `HSSP_ST_ADDR)
                        addr_reg <= rx_byte;
                    if (state_reg == `HSSP_ST_CMD && rx_byte == `HSSP_CMD_NET)
                        net_tx_taken <= 1'b1;
                    if (state_reg == `HSSP_ST_DATA && cmd_reg == `HSSP_CMD_DMA)
                    begin
                        dma_start <= 1'b1;
                        dma_addr <= addr_reg;
                        dma_len <= rx_byte;
                    end
                    if (state_reg == `HSSP_ST_NET)
                    begin
                        net_rx_valid <= 1'b1;
                        net_rx_data <= rx_byte;
                        net_tx_taken <= 1'b1;
                    end
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // register array
    // ----------------------------------------------------------------
    // register write on data byte
    genvar gi;
    generate
        for (gi = 0; gi < `HSSP_REG_DEPTH; gi = gi + 1)
        begin : g_reg
            always @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    mem_reg[gi] <= `HSSP_REG_RESET;
                else if (selected && byte_done && state_reg == `HSSP_ST_DATA
                         && cmd_reg == `HSSP_CMD_REG_WR && addr_idx == gi)
                    mem_reg[gi] <= rx_byte;
            end
        end
    endgenerate
endmodule // hssp_port
`default_nettype wire

// >>> testbench/hssp_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module hssp_port_checker (
    input wire clock,
    input wire rstn,
    input wire spi_sck,
    input wire spi_ssn_n,
    input wire spi_cfg,
    input wire spi_miso_out,
    input wire spi_miso_oe,
    input wire dma_start,
    input wire net_rx_valid,
    input wire net_tx_taken
);
    // ----------------------------------------
    // port timing properties
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_oe_off; spi_ssn_n [*6] |-> !spi_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe while idle");
    property p_oe_on; $fell(spi_ssn_n) && spi_cfg |-> ##[3:5] spi_miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe late");
    property p_oe_cause; $rose(spi_miso_oe) |-> !$past(spi_ssn_n, 2) && $past(spi_cfg, 2); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe without select");
    property p_strap_off; !spi_cfg [*6] |-> !spi_miso_oe; endproperty
    a_strap_off: assert property (p_strap_off) else $error("oe with strap low");
    property p_dma; dma_start |-> !$past(spi_ssn_n, 2) ##1 !dma_start; endproperty
    a_dma: assert property (p_dma) else $error("bad dma pulse");
    property p_net_rx; net_rx_valid |-> !$past(spi_ssn_n, 2) ##1 !net_rx_valid; endproperty
    a_net_rx: assert property (p_net_rx) else $error("bad rx pulse");
    property p_tx_taken; net_tx_taken |-> !$past(spi_ssn_n, 2) ##1 !net_tx_taken; endproperty
    a_tx_taken: assert property (p_tx_taken) else $error("bad load pulse");
    property p_miso_hold;
        ($stable(spi_sck) && $stable(spi_ssn_n)) [*6] |-> $stable(spi_miso_out) || !spi_miso_oe;
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved");
endmodule // hssp_port_checker
bind hssp_port hssp_port_checker i_chk (.clock, .rstn, .spi_sck, .spi_ssn_n, .spi_cfg,
    .spi_miso_out, .spi_miso_oe, .dma_start, .net_rx_valid, .net_tx_taken);
`default_nettype wire

// >>> testbench/hssp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// host serial master, bit time of 8 system clocks
module hssp_master_model (
    input wire clock,
    input wire cpol,
    input wire cpha,
    input wire miso_out,
    input wire miso_oe,
    output reg sck = 1'b0,
    output reg ssn_n = 1'b1,
    output reg mosi = 1'b0
);
    reg miso_hold = 1'b0; // last line level
    wire miso_w = miso_oe ? miso_out : ~miso_hold;
    always @(posedge clock) miso_hold <= miso_w;
    always @(negedge clock) if (ssn_n) sck <= cpol;
    task sel;
    begin
        repeat (2) @(negedge clock);
        ssn_n = 1'b0;
        repeat (8) @(negedge clock);
    end
    endtask
    // close frame, data line no longer meaningful
    task desel;
    begin
        repeat (4) @(negedge clock);
        ssn_n = 1'b1;
        mosi = ~mosi;
        repeat (8) @(negedge clock);
    end
    endtask
    task xfer(input [7:0] tx, input integer nbits, output [7:0] rx);
        integer i;
    begin
        rx = 8'h00;
        for (i = 7; i > 7 - nbits; i = i - 1)
        begin
            if (!cpha) mosi = tx[i];
            repeat (4) @(negedge clock);
            sck = ~cpol;
            if (cpha) mosi = tx[i]; else rx[i] = miso_w;
            repeat (4) @(negedge clock);
            sck = cpol;
            if (cpha) rx[i] = miso_w;
        end
    end
    endtask
endmodule // hssp_master_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg spi_cfg = 1'b1; // strap high except during one write frame
    reg mode_cpol = 1'b0;
    reg mode_cpha = 1'b0;
    reg [7:0] net_tx_data = 8'h00;
    wire spi_sck, spi_ssn_n, spi_mosi, spi_miso_out, spi_miso_oe;
    wire dma_start, net_rx_valid, net_tx_taken;
    wire [7:0] dma_addr, dma_len, net_rx_data;
    integer err_total = 0;
    integer samples_checked = 0;
    integer taken_cnt = 0; // network load pulses seen
    reg [16:0] exp_q[$]; // pending pulse notes
    reg [7:0] rx, a, d;
    integer m;
    wire [16:0] seen_w = dma_start ? {1'b1, dma_addr, dma_len} : {9'h000, net_rx_data};
    always #25 clock = ~clock;
    hssp_port i_hssp_port (.clock, .rstn, .spi_sck, .spi_ssn_n, .spi_mosi, .spi_cfg,
        .mode_cpol, .mode_cpha, .net_tx_data, .spi_miso_out, .spi_miso_oe, .dma_start,
        .dma_addr, .dma_len, .net_rx_valid, .net_rx_data, .net_tx_taken);
    hssp_master_model i_hssp_master_model (.clock, .cpol(mode_cpol), .cpha(mode_cpha),
        .miso_out(spi_miso_out), .miso_oe(spi_miso_oe), .sck(spi_sck), .ssn_n(spi_ssn_n),
        .mosi(spi_mosi));
    task chk(input [16:0] seen, input [16:0] want);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== want)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    end
    endtask
    task close_out;
    begin
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // three-byte frame, last reply left in rx
    task frame(input [7:0] c, input [7:0] x, input [7:0] y);
    begin
        i_hssp_master_model.sel;
        i_hssp_master_model.xfer(c, 8, rx);
        if (spi_cfg) chk({9'h000, rx}, 17'h00000);
        i_hssp_master_model.xfer(x, 8, rx);
        i_hssp_master_model.xfer(y, 8, rx);
        i_hssp_master_model.desel;
    end
    endtask
    // oldest note against each result pulse
    always @(posedge clock)
    begin
        if (dma_start === 1'b1 || net_rx_valid === 1'b1)
            chk(seen_w, exp_q.size() ? exp_q.pop_front() : 17'h1ffff);
        // count network load pulses
        if (net_tx_taken === 1'b1)
            taken_cnt = taken_cnt + 1;
    end
    // watchdog, twelve times the expected run
    initial
    begin
        #2000000;
        err_total = err_total + 1;
        close_out;
    end
    initial
    begin
        m = $urandom(35);
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        frame(8'hc2, 8'h07, 8'h00);
        chk({9'h000, rx}, 17'h00000);
        $display("test reset read done");
        for (m = 0; m < 4; m = m + 1)
        begin
            {mode_cpol, mode_cpha} = m[1:0];
            a = $urandom;
            d = $urandom;
            i_hssp_master_model.sel;
            i_hssp_master_model.xfer(d, 3, rx);
            i_hssp_master_model.desel;
            frame(8'hc1, a, d);
            frame(8'hc2, a, 8'h00);
            chk({9'h000, rx}, {9'h000, d});
        end
        $display("test modes done");
        frame(8'h3c, a, d);
        chk({9'h000, rx}, 17'h00000);
        exp_q.push_back({1'b1, a, d});
        frame(8'hc3, a, d);
        spi_cfg = 1'b0;
        frame(8'hc1, a, ~d);
        spi_cfg = 1'b1;
        frame(8'hc2, a, 8'h00);
        chk({9'h000, rx}, {9'h000, d});
        $display("test command strap done");
        net_tx_data = $urandom;
        i_hssp_master_model.sel;
        i_hssp_master_model.xfer(8'hc4, 8, rx);
        for (m = 0; m < 3; m = m + 1)
        begin
            d = $urandom;
            exp_q.push_back({9'h000, d});
            i_hssp_master_model.xfer(d, 8, rx);
            chk({9'h000, rx}, {9'h000, net_tx_data});
        end
        i_hssp_master_model.desel;
        chk(17'(exp_q.size()), 17'h00000);
        chk(17'(taken_cnt), 17'h00004);
        $display("test stream done");
        close_out;
    end
endmodule // testbench
`default_nettype wire
